// file: rtl/tdrp_cfg.svh
/*
 * constants of the policy block: offsets, resets, fields, codes, timing.
 * assumes inclusion by bare name from the core module.
 */
`ifndef TDRP_CFG_SVH
`define TDRP_CFG_SVH

// ****************************************************************
// register offsets (byte addresses on the plain register port)
// ****************************************************************
`define TDRP_OFS_PAGE_HEADER 8'h00
`define TDRP_OFS_PAGE_LENGTH 8'h01
`define TDRP_OFS_FILL_RATIO 8'h02
`define TDRP_OFS_DRAIN_RATIO 8'h03
`define TDRP_OFS_IDLE_HOLD 8'h04
`define TDRP_OFS_RESEL_WAIT 8'h06
`define TDRP_OFS_TENURE_MAX 8'h08
`define TDRP_OFS_BURST_CAP 8'h0a
`define TDRP_OFS_POLICY 8'h0c
`define TDRP_OFS_STATUS 8'h10
`define TDRP_OFS_MASK 8'h11
`define TDRP_OFS_IFACE_ID 8'h14

// ****************************************************************
// page contents, resets, encodings, status bits and timing
// ****************************************************************
`define TDRP_PAGE_CODE 6'h02
`define TDRP_PAGE_LEN 8'h0e
`define TDRP_SAVABLE 1'b0
`define TDRP_RST_BYTE 8'h00
`define TDRP_RST_WORD 16'h0000
`define TDRP_RST_POLICY 2'h0
`define TDRP_RST_IFACE 16'h0000

`define TDRP_POL_FREE 2'h0
`define TDRP_POL_DATA 2'h1
`define TDRP_POL_RSVD 2'h2
`define TDRP_POL_CMD 2'h3
`define TDRP_SENSE_ILLEGAL_REQ 4'h5
`define TDRP_ASC_ILLEGAL_FIELD 8'h26

`define TDRP_ST_DISC 0
`define TDRP_ST_ILLEGAL 1
`define TDRP_ST_RESEL 2
`define TDRP_ST_W 3
`define TDRP_IFACE_STD_MAX 16'h0004
`define TDRP_IFACE_VEND_MIN 16'h8000

`define TDRP_TICK_US 100
`define TDRP_CLK_MHZ 200
`define TDRP_BURST_BYTES 512

`endif

// file: rtl/tdrp_pkg.sv
/*
 * types of the policy block.
 * assumes nothing of its surroundings.
 */
package tdrp_pkg;

    // ****************************************************************
    // connection state of the target on the bus
    // ****************************************************************
    typedef enum logic [1:0] {
        TDRP_IDLE,
        TDRP_CONNECTED,
        TDRP_WAIT,
        TDRP_RESEL
    } tdrp_state_t;

    // data-phase disconnect policy field
    typedef logic [1:0] tdrp_policy_t;

endpackage : tdrp_pkg

// file: rtl/tdrp_core.sv
/*
 * policy core of a bus target: disconnect and reselect decisions, parameter check.
 * assumes status inputs come from sequencer logic on core_clk, unsynchronised.
 */
// The plain strobed port is this design's own decision.
`include "tdrp_cfg.svh"

// Notes on behaviour
// - reads reselect once buffer fill reaches threshold
// - writes reselect once buffer drain reaches threshold
// - threshold is ratio over 256 times buffer
// - zero ratio leaves choice to target, advisory
// - unsupported ratio rounds down to lower one
// - inactivity limit counts 100 us without handshake
// - inactivity expiry disconnects if privileged and allowed
// - zero inactivity limit disables the check
// - wait minimum time before reselection, zero none
// - connect limit bounds tenure, zero is unlimited
// - disconnect after burst cap of 512-byte units
// - policy 00b adds no restriction
// - policy 01b holds connection until data done
// - policy 11b holds connection until command done
// - policy and burst both nonzero gives check condition
// - 16-bit interface identifier with standard/vendor ranges
// - peripheral page relays identifier, header only defined
module tdrp_core #(
    parameter int unsigned TICK_CYCLES = `TDRP_TICK_US * `TDRP_CLK_MHZ
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // bus sequencer status
    input wire logic bsy_held,
    input wire logic req_ack_seen,
    input wire logic byte_moved,
    input wire logic data_started,
    input wire logic data_done,
    input wire logic cmd_done,
    input wire logic read_op,
    input wire logic disc_privilege,
    // buffer occupancy, in buffers
    input wire logic [15:0] buf_total,
    input wire logic [15:0] buf_level,
    // policy decisions
    output logic disconnect_req,
    output logic reselect_req,
    output logic data_lock,
    // parameter check answer
    output logic check_condition,
    output logic [3:0] sense_key,
    output logic [7:0] add_sense_code,
    // peripheral page identifier
    output logic [15:0] iface_id,
    output logic iface_vendor,
    output logic iface_reserved,
    // interrupt
    output logic irq
);

    // ****************************************************************
    // register file
    // ****************************************************************
    logic [7:0] fill_ratio_reg; // numerator over 256, read side
    logic [7:0] drain_ratio_reg; // numerator over 256, write side
    logic [15:0] idle_hold_limit_reg; // ticks without handshake
    logic [15:0] reselect_wait_min_reg; // ticks after release
    logic [15:0] bus_tenure_max_reg; // ticks on the bus
    logic [15:0] burst_cap_reg; // 512-byte units
    tdrp_pkg::tdrp_policy_t data_phase_disconnect_policy_reg;
    logic [15:0] iface_id_reg; // peripheral page identifier
    logic [`TDRP_ST_W-1:0] status_reg; // sticky events
    logic [`TDRP_ST_W-1:0] mask_reg; // interrupt enables
    logic [`TDRP_ST_W-1:0] event_set; // events this cycle
    logic [15:0] rdata_next;
    logic wr_status; // write-one-clear strobe

    assign wr_status = reg_wr && (reg_addr == `TDRP_OFS_STATUS);

    // software-written parameters
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            fill_ratio_reg <= `TDRP_RST_BYTE;
            drain_ratio_reg <= `TDRP_RST_BYTE;
            idle_hold_limit_reg <= `TDRP_RST_WORD;
            reselect_wait_min_reg <= `TDRP_RST_WORD;
            bus_tenure_max_reg <= `TDRP_RST_WORD;
            burst_cap_reg <= `TDRP_RST_WORD;
            data_phase_disconnect_policy_reg <= `TDRP_RST_POLICY;
            iface_id_reg <= `TDRP_RST_IFACE;
            mask_reg <= '0;
        end else if (reg_wr) begin
            unique case (reg_addr)
                `TDRP_OFS_FILL_RATIO: fill_ratio_reg <= reg_wdata[7:0];
                `TDRP_OFS_DRAIN_RATIO: drain_ratio_reg <= reg_wdata[7:0];
                `TDRP_OFS_IDLE_HOLD: idle_hold_limit_reg <= reg_wdata;
                `TDRP_OFS_RESEL_WAIT: reselect_wait_min_reg <= reg_wdata;
                `TDRP_OFS_TENURE_MAX: bus_tenure_max_reg <= reg_wdata;
                `TDRP_OFS_BURST_CAP: burst_cap_reg <= reg_wdata;
                `TDRP_OFS_POLICY: data_phase_disconnect_policy_reg <= reg_wdata[1:0];
                `TDRP_OFS_IFACE_ID: iface_id_reg <= reg_wdata;
                `TDRP_OFS_MASK: mask_reg <= reg_wdata[`TDRP_ST_W-1:0];
                default: ; // header, length, status and holes keep nothing
            endcase
        end
    end

    // read mux; header bits and length are fixed, holes read zero
    always_comb begin
        rdata_next = 16'h0000;
        unique case (reg_addr)
            `TDRP_OFS_PAGE_HEADER: rdata_next = {8'h00, `TDRP_SAVABLE, 1'b0, `TDRP_PAGE_CODE};
            `TDRP_OFS_PAGE_LENGTH: rdata_next = {8'h00, `TDRP_PAGE_LEN};
            `TDRP_OFS_FILL_RATIO: rdata_next = {8'h00, fill_ratio_reg};
            `TDRP_OFS_DRAIN_RATIO: rdata_next = {8'h00, drain_ratio_reg};
            `TDRP_OFS_IDLE_HOLD: rdata_next = idle_hold_limit_reg;
            `TDRP_OFS_RESEL_WAIT: rdata_next = reselect_wait_min_reg;
            `TDRP_OFS_TENURE_MAX: rdata_next = bus_tenure_max_reg;
            `TDRP_OFS_BURST_CAP: rdata_next = burst_cap_reg;
            `TDRP_OFS_POLICY: rdata_next = {14'h0000, data_phase_disconnect_policy_reg};
            `TDRP_OFS_STATUS: rdata_next = {13'h0000, status_reg};
            `TDRP_OFS_MASK: rdata_next = {13'h0000, mask_reg};
            `TDRP_OFS_IFACE_ID: rdata_next = iface_id_reg;
            default: rdata_next = 16'h0000;
        endcase
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 16'h0000;
        end else begin
            reg_rdata <= reg_rd ? rdata_next : 16'h0000;
        end
    end

    // sticky status; a new event beats a clear in the same cycle
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            status_reg <= '0;
        end else begin
            status_reg <= (status_reg & ~(wr_status ? reg_wdata[`TDRP_ST_W-1:0] : '0))
                          | event_set;
        end
    end

    assign irq = |(status_reg & mask_reg);

    // parameter legality and identifier decode
    logic illegal; // current parameter set cannot be accepted
    logic illegal_reg; // previous value, for the event edge

    assign illegal = ((data_phase_disconnect_policy_reg != `TDRP_POL_FREE)
                      && (burst_cap_reg != 16'h0000))
                     || (data_phase_disconnect_policy_reg == `TDRP_POL_RSVD);

    // answer held while the parameters stay illegal
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            illegal_reg <= 1'b0;
            check_condition <= 1'b0;
            sense_key <= 4'h0;
            add_sense_code <= 8'h00;
        end else begin
            illegal_reg <= illegal;
            check_condition <= illegal;
            sense_key <= illegal ? `TDRP_SENSE_ILLEGAL_REQ : 4'h0;
            add_sense_code <= illegal ? `TDRP_ASC_ILLEGAL_FIELD : 8'h00;
        end
    end

    // the identifier is relayed as is; only its class is decoded here
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            iface_id <= `TDRP_RST_IFACE;
            iface_vendor <= 1'b0;
            iface_reserved <= 1'b0;
        end else begin
            iface_id <= iface_id_reg;
            iface_vendor <= (iface_id_reg >= `TDRP_IFACE_VEND_MIN);
            iface_reserved <= (iface_id_reg > `TDRP_IFACE_STD_MAX)
                              && (iface_id_reg < `TDRP_IFACE_VEND_MIN);
        end
    end

    // 100 us tick and tick counters
    logic [31:0] tick_cnt_reg; // system clocks within one tick
    logic tick; // one-cycle pulse every 100 us
    logic [15:0] idle_cnt_reg; // ticks since the last handshake
    logic [15:0] tenure_cnt_reg; // ticks since connecting
    logic [15:0] wait_cnt_reg; // ticks since releasing the bus
    logic [8:0] byte_cnt_reg; // bytes within the current unit
    logic [15:0] unit_cnt_reg; // 512-byte units this connection
    tdrp_pkg::tdrp_state_t state_reg;

    // saturating increment, so long waits never wrap to a short one
    function automatic logic [15:0] sat_inc(input logic [15:0] v);
        sat_inc = (v == 16'hffff) ? v : v + 16'h0001;
    endfunction

    assign tick = (tick_cnt_reg == TICK_CYCLES - 1);

    // free-running tick divider
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            tick_cnt_reg <= 32'h0000_0000;
        end else begin
            tick_cnt_reg <= tick ? 32'h0000_0000 : tick_cnt_reg + 32'h0000_0001;
        end
    end

    // inactivity: any handshake restarts it, counting only while connected
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            idle_cnt_reg <= 16'h0000;
        end else if (!bsy_held || req_ack_seen) begin
            idle_cnt_reg <= 16'h0000;
        end else if (tick) begin
            idle_cnt_reg <= sat_inc(idle_cnt_reg);
        end
    end

    // tenure: counts from connection until the bus is released
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            tenure_cnt_reg <= 16'h0000;
        end else if (!bsy_held) begin
            tenure_cnt_reg <= 16'h0000;
        end else if (tick) begin
            tenure_cnt_reg <= sat_inc(tenure_cnt_reg);
        end
    end

    // release wait: counts while the target stays off the bus
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            wait_cnt_reg <= 16'h0000;
        end else if (bsy_held) begin
            wait_cnt_reg <= 16'h0000;
        end else if (tick) begin
            wait_cnt_reg <= sat_inc(wait_cnt_reg);
        end
    end

    // burst amount moved in this connection, in 512-byte units
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            byte_cnt_reg <= 9'h000;
            unit_cnt_reg <= 16'h0000;
        end else if (!bsy_held) begin
            byte_cnt_reg <= 9'h000;
            unit_cnt_reg <= 16'h0000;
        end else if (byte_moved) begin
            byte_cnt_reg <= byte_cnt_reg + 9'h001; // wraps at 512 bytes
            if (byte_cnt_reg == 9'(`TDRP_BURST_BYTES - 1)) begin
                unit_cnt_reg <= sat_inc(unit_cnt_reg);
            end
        end
    end

    // ****************************************************************
    // data-phase lock
    // ****************************************************************
    // the lock spans disconnects too: policy 11b holds to command end
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            data_lock <= 1'b0;
        end else if (data_phase_disconnect_policy_reg == `TDRP_POL_DATA) begin
            if (data_done) begin
                data_lock <= 1'b0;
            end else if (data_started) begin
                data_lock <= 1'b1;
            end
        end else if (data_phase_disconnect_policy_reg == `TDRP_POL_CMD) begin
            if (cmd_done) begin
                data_lock <= 1'b0;
            end else if (data_started) begin
                data_lock <= 1'b1;
            end
        end else begin
            data_lock <= 1'b0;
        end
    end

    // disconnect decision
    logic may_disconnect; // privilege granted and policy not locking
    logic idle_expired;
    logic tenure_expired;
    logic burst_reached;
    logic want_disc;

    assign may_disconnect = disc_privilege && !data_lock;
    assign idle_expired = (idle_hold_limit_reg != 16'h0000)
                          && (idle_cnt_reg >= idle_hold_limit_reg);
    assign tenure_expired = (bus_tenure_max_reg != 16'h0000)
                            && (tenure_cnt_reg >= bus_tenure_max_reg);
    assign burst_reached = (burst_cap_reg != 16'h0000)
                           && (unit_cnt_reg >= burst_cap_reg);
    assign want_disc = may_disconnect
                       && (idle_expired || tenure_expired || burst_reached);

    // reselection threshold
    logic [23:0] fill_prod; // ratio times buffers, before the /256
    logic [23:0] drain_prod;
    logic [15:0] free_bufs; // buffers already drained
    logic buf_ok; // buffer condition for the current direction
    logic wait_ok; // minimum release wait has passed

    // integer floor of ratio/256 is the lower supported threshold
    assign fill_prod = fill_ratio_reg * buf_total;
    assign drain_prod = drain_ratio_reg * buf_total;
    assign free_bufs = (buf_total > buf_level) ? buf_total - buf_level : 16'h0000;

    // a zero ratio leaves the moment to the release wait alone
    always_comb begin
        buf_ok = 1'b1;
        if (read_op) begin
            buf_ok = (fill_ratio_reg == 8'h00)
                     || (buf_level >= fill_prod[23:8]);
        end else begin
            buf_ok = (drain_ratio_reg == 8'h00)
                     || (free_bufs >= drain_prod[23:8]);
        end
    end

    assign wait_ok = (reselect_wait_min_reg == 16'h0000)
                     || (wait_cnt_reg >= reselect_wait_min_reg);

    // ****************************************************************
    // connection state machine
    // ****************************************************************
    // idle: no pending command; wait: released, command still open
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= tdrp_pkg::TDRP_IDLE;
        end else begin
            unique case (state_reg)
                tdrp_pkg::TDRP_IDLE: begin
                    if (bsy_held) begin
                        state_reg <= tdrp_pkg::TDRP_CONNECTED;
                    end
                end
                tdrp_pkg::TDRP_CONNECTED: begin
                    if (cmd_done) begin
                        state_reg <= tdrp_pkg::TDRP_IDLE;
                    end else if (!bsy_held) begin
                        state_reg <= tdrp_pkg::TDRP_WAIT;
                    end
                end
                tdrp_pkg::TDRP_WAIT: begin
                    if (bsy_held) begin
                        state_reg <= tdrp_pkg::TDRP_CONNECTED;
                    end else if (wait_ok && buf_ok) begin
                        state_reg <= tdrp_pkg::TDRP_RESEL;
                    end
                end
                tdrp_pkg::TDRP_RESEL: begin
                    if (bsy_held) begin
                        state_reg <= tdrp_pkg::TDRP_CONNECTED;
                    end
                end
            endcase
        end
    end

    // reselect held until the sequencer connects; disconnect only while its condition holds
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            disconnect_req <= 1'b0;
            reselect_req <= 1'b0;
        end else begin
            disconnect_req <= bsy_held && (state_reg == tdrp_pkg::TDRP_CONNECTED)
                              && want_disc;
            reselect_req <= !bsy_held && (state_reg == tdrp_pkg::TDRP_RESEL);
        end
    end

    // events: disconnect asked, parameters turned illegal, reselect ready
    always_comb begin
        event_set = '0;
        event_set[`TDRP_ST_DISC] = bsy_held && (state_reg == tdrp_pkg::TDRP_CONNECTED)
                                   && want_disc && !disconnect_req;
        event_set[`TDRP_ST_ILLEGAL] = illegal && !illegal_reg;
        event_set[`TDRP_ST_RESEL] = (state_reg == tdrp_pkg::TDRP_WAIT) && !bsy_held
                                    && wait_ok && buf_ok;
    end

endmodule // tdrp_core

// file: verification/tdrp_properties.sv
/* port checker of the policy core.
   assumes a bind from tb_top; one clock, reset by arst_n. */
module tdrp_properties (
    // clock and inputs
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic bsy_held,
    input wire logic disc_privilege,
    // outputs watched
    input wire logic [15:0] reg_rdata,
    input wire logic disconnect_req,
    input wire logic reselect_req,
    input wire logic data_lock,
    input wire logic check_condition,
    input wire logic [3:0] sense_key,
    input wire logic [7:0] add_sense_code,
    input wire logic [15:0] iface_id,
    input wire logic iface_vendor,
    input wire logic iface_reserved
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // properties
    // ****************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0)
        else $error("read data outside its cycle");
    a_sense_key: assert property (sense_key == (check_condition ? 4'h5 : 4'h0))
        else $error("sense key wrong");
    a_sense_code: assert property (add_sense_code == (check_condition ? 8'h26 : 8'h0))
        else $error("additional sense wrong");
    a_vendor_range: assert property (iface_vendor == iface_id[15])
        else $error("vendor flag wrong");
    a_rsvd_range: assert property (iface_reserved == (iface_id > 16'h4 && !iface_id[15]))
        else $error("reserved flag wrong");
    a_disc_bus: assert property (!bsy_held |=> !disconnect_req)
        else $error("disconnect while released");
    a_disc_priv: assert property (!disc_privilege |=> !disconnect_req)
        else $error("disconnect without privilege");
    a_lock_holds: assert property (data_lock && $past(data_lock) |-> !disconnect_req)
        else $error("disconnect while locked");
    a_resel_drop: assert property (bsy_held |=> !reselect_req)
        else $error("reselect while connected");
    a_rsvd_policy: assert property (reg_wr && reg_addr == 8'h0c && reg_wdata[1:0] == 2'h2
        |=> ##[0:1] check_condition) else $error("reserved policy accepted");
endmodule // tdrp_properties

// file: verification/tdrp_partner.sv
/* far side of the bus for the policy core.
   assumes the core's clock and reset; the bench commands go and talk. */
module tdrp_partner (
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // bench commands and core decisions
    input wire logic go,
    input wire logic talk,
    input wire logic disconnect_req,
    input wire logic reselect_req,
    // bus status to the core
    output logic bsy_held,
    output logic req_ack_seen
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] beat_reg; // handshakes four cycles apart
    // connection: release wins over a new selection
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            bsy_held <= 1'b0;
        end else if (disconnect_req) begin
            bsy_held <= 1'b0;
        end else if (go || reselect_req) begin
            bsy_held <= 1'b1;
        end
    end
    // handshakes only while connected and talking
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            beat_reg <= 2'h0;
            req_ack_seen <= 1'b0;
        end else begin
            beat_reg <= beat_reg + 2'h1;
            req_ack_seen <= talk && bsy_held && beat_reg == 2'h0;
        end
    end
endmodule // tdrp_partner

// file: verification/tb_top.sv
/* self-checking bench of the policy core with a register model.
   assumes a short tick so a 100 us unit is a few cycles. */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TICK = 10; // shortened tick
    logic core_clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h0;
    logic [15:0] reg_wdata = 16'h0, reg_rdata, iface_id;
    logic go = 1'b0, talk = 1'b0, data_started = 1'b0, data_done = 1'b0;
    logic disc_privilege = 1'b0, bsy_held, req_ack_seen, disconnect_req, reselect_req;
    logic data_lock, check_condition, iface_vendor, iface_reserved, irq;
    logic [3:0] sense_key;
    logic [7:0] add_sense_code;
    logic [15:0] mdl [0:31]; // expected register contents
    logic [7:0] rw_list [10] = '{8'h02, 8'h03, 8'h04, 8'h06, 8'h08, 8'h0a, 8'h0c, 8'h11,
        8'h00, 8'h01};
    logic [15:0] ids [5] = '{16'h4, 16'h5, 16'h7fff, 16'h8000, 16'h0};
    int seed = 32'h018b, failures = 0, samples_checked = 0, n;
    always #2.5 core_clk = ~core_clk;
    tdrp_core #(.TICK_CYCLES(TICK)) u_tdrp_core (.core_clk, .arst_n, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .bsy_held, .req_ack_seen, .byte_moved(1'b0),
        .data_started, .data_done, .cmd_done(1'b0), .read_op(1'b1), .disc_privilege,
        .buf_total(16'h000a), .buf_level(16'h0), .disconnect_req, .reselect_req, .data_lock,
        .check_condition, .sense_key, .add_sense_code, .iface_id, .iface_vendor,
        .iface_reserved, .irq);
    tdrp_partner u_tdrp_partner (.core_clk, .arst_n, .go, .talk, .disconnect_req,
        .reselect_req, .bsy_held, .req_ack_seen);
    // writable bits of each offset; zero means refused
    function automatic logic [15:0] msk(input logic [7:0] a);
        case (a)
            8'h02, 8'h03: msk = 16'h00ff;
            8'h04, 8'h06, 8'h08, 8'h0a, 8'h14: msk = 16'hffff;
            8'h0c: msk = 16'h0003;
            8'h11: msk = 16'h0007;
            default: msk = 16'h0;
        endcase
    endfunction
    task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("FAIL %s expected %h seen %h", s, e, g);
        end
    endtask
    // one-cycle write; status takes write-one-to-clear
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge core_clk);
        reg_wr <= 1'b0;
        if (a == 8'h10) mdl[16] = mdl[16] & ~d;
        else mdl[a[4:0]] = (mdl[a[4:0]] & ~msk(a)) | (d & msk(a));
        #1;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge core_clk);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk("rdata", a < 8'h20 ? mdl[a[4:0]] : 16'h0, reg_rdata);
    endtask
    task automatic pulse(input int k);
        @(posedge core_clk);
        if (k == 0) go <= 1'b1;
        else if (k == 1) data_started <= 1'b1;
        else data_done <= 1'b1;
        @(posedge core_clk);
        {go, data_started, data_done} <= 3'b0;
    endtask
    // bounded wait for disconnect (0) or reselect (1)
    task automatic wait_on(input bit sel);
        n = 0;
        while ((sel ? reselect_req : disconnect_req) !== 1'b1 && n < 4 * TICK) begin
            @(posedge core_clk);
            #1 n++;
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        #200us failures++;
        give_verdict();
    end
    initial begin
        foreach (mdl[i]) mdl[i] = 16'h0;
        {mdl[0], mdl[1]} = {16'h0002, 16'h000e};
        repeat (3) @(posedge core_clk);
        arst_n <= 1'b1;
        for (int a = 0; a < 22; a++) rd(a[7:0]); // [regtable]
        rd(8'h20); // [regtable]
        $display("test reset done");
        repeat (3) begin
            foreach (rw_list[i]) wr(rw_list[i], 16'($random(seed)));
            foreach (rw_list[i]) rd(rw_list[i]); // [regtable]
        end
        $display("test registers done");
        for (int p = 0; p < 8; p++) begin
            wr(8'h0a, 16'(p / 4));
            wr(8'h0c, 16'(p % 4));
            repeat (2) @(posedge core_clk);
            #1 chk("check", 16'(p % 4 == 2 || (p % 4 && p > 3)), 16'(check_condition));
        end
        wr(8'h0a, 16'h0);
        wr(8'h0c, 16'h0);
        wr(8'h10, 16'h7);
        ids[4] = 16'($random(seed));
        foreach (ids[i]) begin
            wr(8'h14, ids[i]);
            repeat (2) @(posedge core_clk);
            #1 chk("id", ids[i], iface_id);
            chk("rsvd", 16'(ids[i] > 16'h4 && !ids[i][15]), 16'(iface_reserved));
            chk("vendor", 16'(ids[i] >= 16'h8000), 16'(iface_vendor));
        end
        $display("test legality and identifier done");
        wr(8'h11, 16'h7);
        wr(8'h06, 16'h2);
        wr(8'h02, 16'h0);
        wr(8'h08, 16'h0);
        wr(8'h04, 16'h1);
        @(posedge core_clk);
        disc_privilege <= 1'b1;
        pulse(0);
        wait_on(0);
        chk("disc", 16'h1, 16'(disconnect_req));
        @(posedge core_clk);
        disc_privilege <= 1'b0;
        wait_on(1);
        chk("wait", 16'h1, 16'(n >= TICK && reselect_req));
        chk("irq", 16'h1, 16'(irq));
        wr(8'h11, 16'h0);
        chk("irq", 16'h0, 16'(irq));
        wr(8'h11, 16'h7);
        chk("irq", 16'h1, 16'(irq));
        wr(8'h10, 16'h7);
        chk("irq", 16'h0, 16'(irq));
        $display("test disconnect and interrupt done");
        @(posedge core_clk);
        talk <= 1'b1;
        wr(8'h04, 16'h2);
        repeat (8) @(posedge core_clk);
        disc_privilege <= 1'b1;
        wait_on(0);
        chk("disc", 16'h0, 16'(disconnect_req));
        wr(8'h04, 16'h0);
        @(posedge core_clk) talk <= 1'b0;
        wait_on(0);
        chk("disc", 16'h0, 16'(disconnect_req));
        wr(8'h0c, 16'h1);
        pulse(1);
        wr(8'h04, 16'h1);
        wait_on(0);
        chk("lock", 16'h1, {15'h0, data_lock & ~disconnect_req});
        pulse(2);
        wait_on(0);
        chk("disc", 16'h1, 16'(disconnect_req));
        $display("test limits and lock done");
        give_verdict();
    end
endmodule // tb_top
bind tdrp_core tdrp_properties u_tdrp_properties (.core_clk, .arst_n, .reg_rd, .reg_wr,
    .reg_addr, .reg_wdata, .bsy_held, .disc_privilege, .reg_rdata, .disconnect_req,
    .reselect_req, .data_lock, .check_condition, .sense_key, .add_sense_code, .iface_id,
    .iface_vendor, .iface_reserved);
